// File: hw/wake_pkg.sv
// Package for the high-voltage wake input block: register map, fields, timing.
// Assumes a 20 MHz clock and a simple address/strobe register port.
package wake_pkg;

    // Register byte addresses.
    localparam logic [7:0] ADDR_WAKE_CONTROL   = 8'h00;
    localparam logic [7:0] ADDR_PULL_CONTROL   = 8'h04;
    localparam logic [7:0] ADDR_MODE_CONTROL   = 8'h08;
    localparam logic [7:0] ADDR_STATUS_FIRST   = 8'h0c;
    localparam logic [7:0] ADDR_STATUS_SECOND  = 8'h10;
    localparam logic [7:0] ADDR_LEVEL_STATUS   = 8'h14;
    localparam logic [7:0] ADDR_SLEEP_REQUEST  = 8'h18;
    localparam logic [7:0] ADDR_ERROR_STATUS   = 8'h1c;

    // Field positions.
    localparam int BIT_WAKE_EN        = 0;
    localparam int BIT_CYCLIC_SEL     = 1;
    localparam int BIT_MEASURE_EN     = 2;
    localparam int BIT_GP_AS_WAKE     = 3;
    localparam int BIT_OTHER_SOURCES  = 4;
    localparam int BIT_PIN_EVENT      = 0;
    localparam int BIT_GP_EVENT       = 0;
    localparam int BIT_LEVEL_PIN      = 0;
    localparam int BIT_LEVEL_GP       = 1;
    localparam int BIT_SPI_ERROR      = 0;
    localparam int BIT_SLEEP_GO       = 0;

    // Reset values.
    localparam logic [31:0] RESET_WAKE_CONTROL = 32'h0000_0001;
    localparam logic [1:0]  RESET_PULL_SELECT  = 2'h0;
    localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

    // Pull select encoding.
    typedef enum logic [1:0] {
        PULL_NONE = 2'h0,
        PULL_DOWN = 2'h1,
        PULL_UP   = 2'h2,
        PULL_AUTO = 2'h3
    } pull_sel_t;

    // Power modes as presented by the mode controller.
    typedef enum logic [2:0] {
        PM_INIT     = 3'h0,
        PM_NORMAL   = 3'h1,
        PM_STOP     = 3'h2,
        PM_SLEEP    = 3'h3,
        PM_FAILSAFE = 3'h4,
        PM_RESTART  = 3'h5
    } power_mode_t;

    // Filter timing.
    localparam int CLOCK_HZ         = 20_000_000;
    localparam int FILTER_TIME_NS   = 16_000;
    localparam int FILTER_CYCLES    = (FILTER_TIME_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
    localparam int FILTER_CNT_W     = 9;

    // Pull source drive pair.
    typedef struct packed {
        logic pull_up;
        logic pull_down;
    } pull_drive_t;

    // Outward wake signalling.
    typedef struct packed {
        logic interrupt;
        logic wake_up;
    } wake_signal_t;

endpackage

// File: hw/wake_sync.sv
// Three-stage synchroniser with agreement on the last two stages.
// Assumes the input is asynchronous to clock_in.
`timescale 1ns/100ps
module wake_sync (
    // Clock and reset.
    input  wire logic clock_in,
    input  wire logic reset_in,
    // Data.
    input  wire logic async_in,
    output logic      level_out
);
    logic stage1_ff;
    logic stage2_ff;
    logic stage3_ff;
    logic level_ff;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
            stage3_ff <= 1'b0;
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    // A change counts once the second and third stages agree.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            level_ff <= 1'b0;
        end else if (stage2_ff == stage3_ff) begin
            level_ff <= stage3_ff;
        end
    end

    assign level_out = level_ff;
endmodule

// File: hw/wake_filter.sv
// Deglitch filter: a level is accepted after it stays stable for the filter time.
// Assumes a synchronised input on the same clock.
`timescale 1ns/100ps
module wake_filter (
    // Clock and reset.
    input  wire logic clock_in,
    input  wire logic reset_in,
    // Data.
    input  wire logic enable_in,
    input  wire logic level_in,
    output logic      filtered_out,
    output logic      edge_out
);
    logic                                 last_ff;
    logic                                 filt_ff;
    logic                                 edge_ff;
    logic [wake_pkg::FILTER_CNT_W-1:0]    count_ff;

    localparam logic [wake_pkg::FILTER_CNT_W-1:0] LIMIT =
        wake_pkg::FILTER_CNT_W'(wake_pkg::FILTER_CYCLES - 1);

    // Every crossing restarts the count; acceptance needs a full stable interval.
    always_ff @(posedge clock_in) begin
        if (reset_in || !enable_in) begin
            last_ff  <= 1'b0;
            filt_ff  <= 1'b0;
            edge_ff  <= 1'b0;
            count_ff <= '0;
        end else begin
            last_ff <= level_in;
            edge_ff <= 1'b0;
            if (level_in != last_ff) begin
                count_ff <= '0;
            end else if (level_in != filt_ff) begin
                if (count_ff == LIMIT) begin
                    filt_ff  <= level_in;
                    edge_ff  <= 1'b1;
                    count_ff <= '0;
                end else begin
                    count_ff <= count_ff + 1'b1;
                end
            end else begin
                count_ff <= '0;
            end
        end
    end

    assign filtered_out = filt_ff;
    assign edge_out     = edge_ff;
endmodule

// File: hw/wake_input.sv
// Function
// - Both pin edges produce a wake event
// - Interrupt in Normal/Stop, wake-up in Sleep/Fail-Safe
// - Software selects static or cyclic sensing
// - Static sensing evaluates the pin continuously
// - Cyclic sensing evaluates only during active window
// - Static sensing uses a 16 us filter
// - Crossing restarts filter; accept if stable throughout
// - Control bit enables pin wake capability
// - Accepted pin events latch in first status
// - Live level shown in Normal, Stop, Init
// - Cyclic sensing shows last sampled level
// - General pin as wake: filtered, second status
// - Pull select: none, down, up, automatic
// - Automatic: pull-up when high, pull-down when low
// - Cyclic: sample at end of switch on-time, event on change
// - Measurement disables fail output, general pin, wake
// - Measurement switches pulls off, blocks wake signal
// - Measurement ignores settings, writes still accepted
// - Measurement freezes first status, clears level bits
// - Sleep while measuring with only pin source: error, restart
// - Interrupt only if source enabled for wake
//
// Wake input logic with register port.
// Assumes outside power mode and switch timer inputs.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
module wake_input (
    // Clock and reset.
    input  wire logic                    clock_in,
    input  wire logic                    reset_in,
    // Pins and system.
    input  wire logic                    wake_input_pin_in,
    input  wire logic                    fail_general_pin_in,
    input  wire logic                    high_side_switch_on_in,
    input  wire wake_pkg::power_mode_t   power_mode_in,
    // Register port.
    input  wire logic [7:0]              reg_addr_in,
    input  wire logic [31:0]             reg_wdata_in,
    input  wire logic                    reg_write_in,
    input  wire logic                    reg_read_in,
    output logic [31:0]                  reg_rdata_out,
    // Outputs.
    output wake_pkg::wake_signal_t       wake_signal_out,
    output wake_pkg::pull_drive_t        pull_drive_out,
    output logic                         fail_output_test_out,
    output logic                         general_pin_func_out,
    output logic                         restart_request_out,
    output logic                         sleep_accept_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // Control registers.
    logic [31:0]        wake_control_reg_ff;
    logic [1:0]         pull_select_field_ff;
    logic               wake_pin_event_flag_ff;
    logic               gp_event_flag_ff;
    logic [1:0]         wake_level_status_ff;
    logic               spi_error_ff;
    logic [31:0]        rdata_ff;

    logic wake_en;
    logic cyclic_sel;
    logic hv_measure_enable;
    logic gp_as_wake;
    logic other_sources;

    assign wake_en           = wake_control_reg_ff[wake_pkg::BIT_WAKE_EN];
    assign cyclic_sel        = wake_control_reg_ff[wake_pkg::BIT_CYCLIC_SEL];
    assign hv_measure_enable = wake_control_reg_ff[wake_pkg::BIT_MEASURE_EN];
    assign gp_as_wake        = wake_control_reg_ff[wake_pkg::BIT_GP_AS_WAKE];
    assign other_sources     = wake_control_reg_ff[wake_pkg::BIT_OTHER_SOURCES];

    function automatic logic is_hit(input logic [7:0] addr, input logic [7:0] target);
        is_hit = (addr == target);
    endfunction

    logic wr_control;
    logic wr_pull;
    logic rd_status1;
    logic rd_status2;
    logic rd_error;
    logic wr_sleep;

    assign wr_control = reg_write_in && is_hit(reg_addr_in, wake_pkg::ADDR_WAKE_CONTROL);
    assign wr_pull    = reg_write_in && is_hit(reg_addr_in, wake_pkg::ADDR_PULL_CONTROL);
    assign wr_sleep   = reg_write_in && is_hit(reg_addr_in, wake_pkg::ADDR_SLEEP_REQUEST)
                        && reg_wdata_in[wake_pkg::BIT_SLEEP_GO];
    assign rd_status1 = reg_read_in && is_hit(reg_addr_in, wake_pkg::ADDR_STATUS_FIRST);
    assign rd_status2 = reg_read_in && is_hit(reg_addr_in, wake_pkg::ADDR_STATUS_SECOND);
    assign rd_error   = reg_read_in && is_hit(reg_addr_in, wake_pkg::ADDR_ERROR_STATUS);

    // Writes land even while measuring.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            wake_control_reg_ff <= wake_pkg::RESET_WAKE_CONTROL;
        end else if (wr_control) begin
            wake_control_reg_ff <= reg_wdata_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pull_select_field_ff <= wake_pkg::RESET_PULL_SELECT;
        end else if (wr_pull) begin
            pull_select_field_ff <= reg_wdata_in[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisation and filtering.
    logic pin_sync;
    logic gp_sync;
    logic hs_on;
    logic pin_filt;
    logic pin_edge;
    logic gp_filt;
    logic gp_edge;
    logic static_active;
    logic gp_active;

    wake_sync u_sync_pin (
        .clock_in  (clock_in),
        .reset_in  (reset_in),
        .async_in  (wake_input_pin_in),
        .level_out (pin_sync)
    );

    wake_sync u_sync_gp (
        .clock_in  (clock_in),
        .reset_in  (reset_in),
        .async_in  (fail_general_pin_in),
        .level_out (gp_sync)
    );

    wake_sync u_sync_hs (
        .clock_in  (clock_in),
        .reset_in  (reset_in),
        .async_in  (high_side_switch_on_in),
        .level_out (hs_on)
    );

    // Measurement gates the wake path off.
    assign static_active = !hv_measure_enable && !cyclic_sel;
    assign gp_active     = !hv_measure_enable && gp_as_wake;

    wake_filter u_filter_pin (
        .clock_in     (clock_in),
        .reset_in     (reset_in),
        .enable_in    (static_active),
        .level_in     (pin_sync),
        .filtered_out (pin_filt),
        .edge_out     (pin_edge)
    );

    wake_filter u_filter_gp (
        .clock_in     (clock_in),
        .reset_in     (reset_in),
        .enable_in    (gp_active),
        .level_in     (gp_sync),
        .filtered_out (gp_filt),
        .edge_out     (gp_edge)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Cyclic sensing: sample at the end of each switch on-time.
    logic hs_on_d_ff;
    logic sampled_ff;
    logic sample_valid_ff;
    logic cyc_edge_ff;
    logic hs_end;

    assign hs_end = hs_on_d_ff && !hs_on;

    always_ff @(posedge clock_in) begin
        if (reset_in || hv_measure_enable || !cyclic_sel) begin
            hs_on_d_ff      <= 1'b0;
            sampled_ff      <= 1'b0;
            sample_valid_ff <= 1'b0;
            cyc_edge_ff     <= 1'b0;
        end else begin
            hs_on_d_ff  <= hs_on;
            cyc_edge_ff <= 1'b0;
            if (hs_end) begin
                sampled_ff      <= pin_sync;
                sample_valid_ff <= 1'b1;
                cyc_edge_ff     <= sample_valid_ff && (pin_sync != sampled_ff);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event latching and level status.
    logic pin_event;
    logic gp_event;
    logic level_mode;

    assign pin_event  = (pin_edge || cyc_edge_ff) && wake_en && !hv_measure_enable;
    assign gp_event   = gp_edge;
    assign level_mode = (power_mode_in == wake_pkg::PM_NORMAL) ||
                        (power_mode_in == wake_pkg::PM_STOP) ||
                        (power_mode_in == wake_pkg::PM_INIT);

    // A set in the same cycle as a read-clear wins.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            wake_pin_event_flag_ff <= 1'b0;
        end else if (pin_event) begin
            wake_pin_event_flag_ff <= 1'b1;
        end else if (rd_status1 && !hv_measure_enable) begin
            wake_pin_event_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            gp_event_flag_ff <= 1'b0;
        end else if (gp_event) begin
            gp_event_flag_ff <= 1'b1;
        end else if (rd_status2) begin
            gp_event_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in || hv_measure_enable) begin
            wake_level_status_ff <= 2'h0;
        end else if (level_mode) begin
            wake_level_status_ff[wake_pkg::BIT_LEVEL_PIN] <=
                cyclic_sel ? sampled_ff : pin_sync;
            wake_level_status_ff[wake_pkg::BIT_LEVEL_GP]  <= gp_as_wake ? gp_filt : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Signalling: interrupt or wake-up by power mode.
    logic any_event;
    logic int_mode;
    logic wake_mode;

    // Source enables already gate both events.
    assign any_event = pin_event || gp_event;
    assign int_mode  = (power_mode_in == wake_pkg::PM_NORMAL) ||
                       (power_mode_in == wake_pkg::PM_STOP);
    assign wake_mode = (power_mode_in == wake_pkg::PM_SLEEP) ||
                       (power_mode_in == wake_pkg::PM_FAILSAFE);

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            wake_signal_out <= '0;
        end else begin
            wake_signal_out.interrupt <= any_event && int_mode;
            wake_signal_out.wake_up   <= any_event && wake_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pull source drive.
    always_ff @(posedge clock_in) begin
        if (reset_in || hv_measure_enable) begin
            pull_drive_out <= '0;
        end else begin
            case (wake_pkg::pull_sel_t'(pull_select_field_ff))
                wake_pkg::PULL_NONE: pull_drive_out <= '0;
                wake_pkg::PULL_DOWN: begin
                    pull_drive_out.pull_up   <= 1'b0;
                    pull_drive_out.pull_down <= 1'b1;
                end
                wake_pkg::PULL_UP: begin
                    pull_drive_out.pull_up   <= 1'b1;
                    pull_drive_out.pull_down <= 1'b0;
                end
                wake_pkg::PULL_AUTO: begin
                    pull_drive_out.pull_up   <= pin_sync;
                    pull_drive_out.pull_down <= !pin_sync;
                end
                default: pull_drive_out <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Measurement gating of the general pin functions.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            fail_output_test_out <= 1'b0;
            general_pin_func_out <= 1'b0;
        end else begin
            fail_output_test_out <= !hv_measure_enable;
            general_pin_func_out <= !hv_measure_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sleep request check.
    logic only_pin_source;

    assign only_pin_source = wake_en && !other_sources && !(gp_as_wake && !hv_measure_enable);

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            spi_error_ff        <= 1'b0;
            restart_request_out <= 1'b0;
            sleep_accept_out    <= 1'b0;
        end else begin
            restart_request_out <= 1'b0;
            sleep_accept_out    <= 1'b0;
            if (wr_sleep && hv_measure_enable && only_pin_source) begin
                spi_error_ff        <= 1'b1;
                restart_request_out <= 1'b1;
            end else begin
                if (wr_sleep) begin
                    sleep_accept_out <= 1'b1;
                end
                if (rd_error) begin
                    spi_error_ff <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, valid in the cycle after the read strobe.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rdata_ff <= wake_pkg::READ_ZERO;
        end else if (reg_read_in) begin
            rdata_ff <= wake_pkg::READ_ZERO;
            case (reg_addr_in)
                wake_pkg::ADDR_WAKE_CONTROL:  rdata_ff <= wake_control_reg_ff;
                wake_pkg::ADDR_PULL_CONTROL:  rdata_ff[1:0] <= pull_select_field_ff;
                wake_pkg::ADDR_MODE_CONTROL:  rdata_ff[2:0] <= power_mode_in;
                wake_pkg::ADDR_STATUS_FIRST:
                    rdata_ff[wake_pkg::BIT_PIN_EVENT] <= wake_pin_event_flag_ff;
                wake_pkg::ADDR_STATUS_SECOND:
                    rdata_ff[wake_pkg::BIT_GP_EVENT] <= gp_event_flag_ff;
                wake_pkg::ADDR_LEVEL_STATUS:  rdata_ff[1:0] <= wake_level_status_ff;
                wake_pkg::ADDR_ERROR_STATUS:
                    rdata_ff[wake_pkg::BIT_SPI_ERROR] <= spi_error_ff;
                default:                      rdata_ff <= wake_pkg::READ_ZERO;
            endcase
        end else begin
            rdata_ff <= wake_pkg::READ_ZERO;
        end
    end

    assign reg_rdata_out = rdata_ff;
endmodule

// File: tb/wake_switch_model.sv
// Model of an outside switch or sensor on the wake pins.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/100ps
module wake_switch_model (
    // Clock.
    input  wire logic clock_in,
    // Pins.
    output logic      pin_out,
    output logic      gp_out
);
    initial begin
        pin_out = 1'b0;
        gp_out  = 1'b0;
    end
    task automatic set_level(input logic lv);
        @(posedge clock_in);
        pin_out <= lv;
    endtask
    task automatic set_gp(input logic lv);
        @(posedge clock_in);
        gp_out <= lv;
    endtask
    task automatic bounce(input int len);
        @(posedge clock_in);
        pin_out <= ~pin_out;
        repeat (len) @(posedge clock_in);
        pin_out <= ~pin_out;
    endtask
endmodule

// File: tb/wake_input_sva.sv
// Port checker for the wake input block.
// Assumes it is bound onto wake_input.
`timescale 1ns/100ps
module wake_input_chk (
    input wire logic                   clock_in,
    input wire logic                   reset_in,
    input wire logic                   wake_input_pin_in,
    input wire wake_pkg::power_mode_t  power_mode_in,
    input wire logic [7:0]             reg_addr_in,
    input wire logic                   reg_write_in,
    input wire logic                   reg_read_in,
    input wire logic [31:0]            reg_rdata_out,
    input wire wake_pkg::wake_signal_t wake_signal_out,
    input wire wake_pkg::pull_drive_t  pull_drive_out,
    input wire logic                   fail_output_test_out,
    input wire logic                   general_pin_func_out,
    input wire logic                   restart_request_out,
    input wire logic                   sleep_accept_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    a_irq_awake_mode: assert property (wake_signal_out.interrupt |->
        $past(power_mode_in) inside {wake_pkg::PM_NORMAL, wake_pkg::PM_STOP})
        else $error("interrupt in wrong mode");
    a_wake_sleep_mode: assert property (wake_signal_out.wake_up |->
        $past(power_mode_in) inside {wake_pkg::PM_SLEEP, wake_pkg::PM_FAILSAFE})
        else $error("wake pulse in wrong mode");
    a_pulse_single: assert property (wake_signal_out != 2'h0 |=> wake_signal_out == 2'h0)
        else $error("wake signal too long");
    a_filter_stable: assert property (wake_signal_out != 2'h0 |->
        $past(wake_input_pin_in, 2) == $past(wake_input_pin_in, 300))
        else $error("event without a stable pin");
    a_meas_pulls_off: assert property (!fail_output_test_out |-> pull_drive_out == 2'h0)
        else $error("pull source on while measuring");
    a_meas_wake_quiet: assert property ((!general_pin_func_out &&
        $past(!general_pin_func_out)) |-> wake_signal_out == 2'h0)
        else $error("wake signal while measuring");
    a_pulls_exclusive: assert property (!(pull_drive_out.pull_up && pull_drive_out.pull_down))
        else $error("pull-up and pull-down together");
    a_rdata_idle: assert property (!$past(reg_read_in) |-> reg_rdata_out == 32'h0)
        else $error("stray read data");
    a_restart_cause: assert property (restart_request_out |-> !sleep_accept_out &&
        $past(reg_write_in && reg_addr_in == wake_pkg::ADDR_SLEEP_REQUEST))
        else $error("restart without sleep request");
endmodule
bind wake_input wake_input_chk u_chk (
    .clock_in, .reset_in, .wake_input_pin_in, .power_mode_in, .reg_addr_in, .reg_write_in,
    .reg_read_in, .reg_rdata_out, .wake_signal_out, .pull_drive_out, .fail_output_test_out,
    .general_pin_func_out, .restart_request_out, .sleep_accept_out);

// File: tb/tb.sv
// Self-checking bench for the wake input block.
// Assumes a 20 MHz clock and the switch model on the wake pin.
`timescale 1ns/100ps
module tb;
    localparam logic [7:0] A_CTL = wake_pkg::ADDR_WAKE_CONTROL;
    localparam logic [7:0] A_PUL = wake_pkg::ADDR_PULL_CONTROL;
    localparam logic [7:0] A_ST1 = wake_pkg::ADDR_STATUS_FIRST;
    localparam logic [7:0] A_LVL = wake_pkg::ADDR_LEVEL_STATUS;
    logic                   clock_in = 1'b0;
    logic                   reset_in;
    logic                   hs_on;
    wake_pkg::power_mode_t  mode;
    logic [7:0]             addr;
    logic [31:0]            wdata;
    logic                   wr;
    logic                   rd;
    logic [31:0]            rdata;
    wake_pkg::wake_signal_t sig;
    wake_pkg::pull_drive_t  pull;
    logic                   pin, gp, fo_test, gp_func, restart, sleep_ok;
    logic [31:0]            d;
    int                     err_total = 0;
    int                     comparisons = 0;
    int                     cycles = 0;
    int                     n_irq, n_wk;

    wake_switch_model sw (.clock_in(clock_in), .pin_out(pin), .gp_out(gp));
    wake_input dut (.clock_in(clock_in), .reset_in(reset_in), .wake_input_pin_in(pin),
        .fail_general_pin_in(gp), .high_side_switch_on_in(hs_on), .power_mode_in(mode),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
        .reg_rdata_out(rdata), .wake_signal_out(sig), .pull_drive_out(pull),
        .fail_output_test_out(fo_test), .general_pin_func_out(gp_func),
        .restart_request_out(restart), .sleep_accept_out(sleep_ok));

    always #25 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("errors=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock_in);
        addr <= a; wdata <= v; wr <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock_in);
        addr <= a; rd <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic watch();
        n_irq = 0; n_wk = 0;
        repeat (400) begin
            @(posedge clock_in);
            #1 n_irq += sig.interrupt; n_wk += sig.wake_up;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_reg(A_CTL, d); chk(d, wake_pkg::RESET_WAKE_CONTROL);
        rd_reg(A_PUL, d); chk(d, 32'h0);
        rd_reg(8'h20, d); chk(d, 32'h0);
        chk(fo_test, 1'b1);
    endtask
    task automatic t_modes();
        for (int i = 0; i < 4; i++) begin
            mode <= wake_pkg::power_mode_t'(i + 1);
            sw.set_level(~pin);
            watch();
            chk(n_irq, i < 2);
            chk(n_wk, i >= 2);
            rd_reg(A_ST1, d); chk(d, 32'h1);
            rd_reg(A_ST1, d); chk(d, 32'h0);
        end
        mode <= wake_pkg::PM_NORMAL;
        sw.set_level(1'b1);
        watch();
        rd_reg(A_ST1, d);
        rd_reg(A_LVL, d); chk(d[0], 1'b1);
    endtask
    task automatic t_glitch();
        sw.bounce(300);
        watch();
        chk(n_irq, 0);
        rd_reg(A_ST1, d); chk(d, 32'h0);
    endtask
    task automatic t_enable();
        wr_reg(A_CTL, 32'h0);
        sw.bounce(400);
        watch();
        chk(n_irq, 0);
        rd_reg(A_ST1, d); chk(d, 32'h0);
        wr_reg(A_CTL, 32'h1);
    endtask
    task automatic t_pulls();
        logic [1:0] e [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
        for (int s = 0; s < 4; s++) begin
            wr_reg(A_PUL, s);
            rd_reg(A_PUL, d); chk(d, s);
            chk(pull, e[s]);
        end
        sw.set_level(1'b0);
        watch();
        chk(pull, 2'h1);
        rd_reg(A_ST1, d);
    endtask
    task automatic t_gp();
        wr_reg(A_CTL, 32'h9);
        sw.set_gp(1'b1);
        watch();
        chk(n_irq, 1);
        rd_reg(wake_pkg::ADDR_STATUS_SECOND, d); chk(d, 32'h1);
        rd_reg(A_LVL, d); chk(d[1], 1'b1);
    endtask
    task automatic t_measure();
        wr_reg(A_CTL, 32'h5);
        repeat (3) @(posedge clock_in);
        #1 chk({fo_test, gp_func}, 2'h0);
        chk(pull, 2'h0);
        rd_reg(A_LVL, d); chk(d, 32'h0);
        wr_reg(A_PUL, 32'h1);
        rd_reg(A_PUL, d); chk(d, 32'h1);
        sw.set_level(1'b1);
        watch();
        chk(n_irq, 0);
        rd_reg(A_ST1, d); chk(d, 32'h0);
        wr_reg(wake_pkg::ADDR_SLEEP_REQUEST, 32'h1);
        n_irq = 0;
        repeat (3) begin
            #1 n_irq += restart;
            @(posedge clock_in);
        end
        chk(n_irq, 1);
        rd_reg(wake_pkg::ADDR_ERROR_STATUS, d); chk(d, 32'h1);
        wr_reg(A_CTL, 32'h1);
        wr_reg(wake_pkg::ADDR_SLEEP_REQUEST, 32'h1);
        #1 chk({restart, sleep_ok}, 2'h1);
    endtask
    task automatic t_cyclic();
        wr_reg(A_CTL, 32'h3);
        repeat (2) begin
            @(posedge clock_in) hs_on <= 1'b1;
            repeat (8) @(posedge clock_in);
            hs_on <= 1'b0;
            watch();
        end
        rd_reg(A_ST1, d);
        sw.set_level(1'b0);
        watch();
        chk(n_irq, 0);
        @(posedge clock_in) hs_on <= 1'b1;
        repeat (8) @(posedge clock_in);
        hs_on <= 1'b0;
        watch();
        chk(n_irq, 1);
        sw.set_level(1'b1);
        repeat (20) @(posedge clock_in);
        rd_reg(A_LVL, d); chk(d[0], 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_in = 1'b1;
        hs_on = 1'b0;
        mode = wake_pkg::PM_NORMAL;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (4) @(posedge clock_in);
        reset_in <= 1'b0;
        t_reset();
        t_modes();
        t_glitch();
        t_enable();
        t_pulls();
        t_gp();
        t_measure();
        t_cyclic();
        results();
    end
endmodule
